// ==== hdl/pin_sync.v ====
// three-stage synchroniser with agreement filter for one bus pin
`timescale 1ns/1ps

module pin_sync (
    input wire clk,
    input wire rst_n,
    input wire pin,
    output wire level
);

reg s1_ff;
reg s2_ff;
reg s3_ff;
reg level_ff;

// ------------------------------------------------------------------
// sampling chain
// ------------------------------------------------------------------
// idle bus is high, so the chain resets high to avoid a false start
always @(posedge clk) begin
    if (!rst_n) begin
        s1_ff <= 1'b1;
        s2_ff <= 1'b1;
        s3_ff <= 1'b1;
        level_ff <= 1'b1;
    end else begin
        s1_ff <= pin;
        s2_ff <= s1_ff;
        s3_ff <= s2_ff;
        if (s2_ff == s3_ff) begin
            level_ff <= s3_ff; // a change counts only once two stages agree
        end
    end
end

assign level = level_ff;

endmodule // pin_sync

// ==== hdl/two_wire_defs.vh ====
// register map, field positions, status codes and timing of the two-wire unit
`ifndef TWO_WIRE_DEFS_VH
`define TWO_WIRE_DEFS_VH

// ------------------------------------------------------------------
// register indexes on the plain register port
// ------------------------------------------------------------------
`define REG_CTRL 3'h0
`define REG_STATUS 3'h1
`define REG_DATA 3'h2
`define REG_EVT 3'h3
`define REG_MASK 3'h4

// ------------------------------------------------------------------
// serial_control bit positions
// ------------------------------------------------------------------
`define CTL_FLAG 7
`define CTL_ACK 6
`define CTL_STA 5
`define CTL_STO 4
`define CTL_WC 3
`define CTL_EN 2
`define CTL_RSV 1
`define CTL_IE 0

// ------------------------------------------------------------------
// event bits (event, mask)
// ------------------------------------------------------------------
`define EVT_FLAG 0
`define EVT_ARB 1
`define EVT_STOP 2
`define EVT_W 3

// ------------------------------------------------------------------
// status codes, prescaler bits [2:0] always zero
// ------------------------------------------------------------------
`define ST_START 8'h08
`define ST_RSTART 8'h10
`define ST_W_ACK 8'h18
`define ST_W_NACK 8'h20
`define ST_ARB 8'h38
`define ST_R_ACK 8'h40
`define ST_R_NACK 8'h48
`define ST_D_ACK 8'h50
`define ST_D_NACK 8'h58
`define ST_IDLE 8'hf8

// ------------------------------------------------------------------
// reset values
// ------------------------------------------------------------------
`define CTRL_RST 8'h00
`define DATA_RST 8'hff
`define MASK_RST 3'h0

// ------------------------------------------------------------------
// timing: quarter of a bus bit period
// ------------------------------------------------------------------
`define CLK_PERIOD_NS 10
`define QTR_NS 2500
`define QTR_CYCLES ((`QTR_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ==== hdl/two_wire_master_receiver.v ====
// master-receiver engine of the two-wire unit with its register file
//
// The address-and-strobe port and the register addresses were decided locally.
`timescale 1ns/1ps
`include "two_wire_defs.vh"

module two_wire_master_receiver #(
    parameter QTR = `QTR_CYCLES,
    parameter CW = 12
) (
    input wire clk,
    input wire rst_n,
    input wire [2:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output wire [7:0] reg_rdata,
    input wire scl_i,
    output wire scl_o,
    output wire scl_oe,
    input wire sda_i,
    output wire sda_o,
    output wire sda_oe,
    output wire irq,
    output wire master_rx_mode,
    output wire master_tx_mode
);

// ------------------------------------------------------------------
// states and constants
// ------------------------------------------------------------------
localparam [4:0] S_IDLE = 5'b00001;
localparam [4:0] S_START = 5'b00010;
localparam [4:0] S_HOLD = 5'b00100;
localparam [4:0] S_BITS = 5'b01000;
localparam [4:0] S_STOP = 5'b10000;
localparam integer QTR_M1 = QTR - 1;
localparam [CW-1:0] QTR_LAST = QTR_M1[CW-1:0];
localparam [7:0] CTRL_INIT = `CTRL_RST;

// serial_control fields
reg job_done_flag_ff;
reg ack_enable_ff;
reg start_request_ff;
reg stop_request_ff;
reg write_collision_flag_ff;
reg iface_enable_ff;
reg irq_enable_ff;
// other registers
reg [7:0] status_ff;
reg [7:0] data_ff;
reg [`EVT_W-1:0] evt_ff;
reg [`EVT_W-1:0] mask_ff;
reg [7:0] rdata_ff;
// engine
reg [4:0] state_ff;
reg [1:0] phase_ff;
reg [3:0] bit_ff;
reg [7:0] shift_ff;
reg [CW-1:0] cnt_ff;
reg scl_drv_ff;
reg sda_drv_ff;
reg hold_scl_ff;
reg rep_ff;
reg pend_ff;
reg addr_phase_ff;
reg rd_dir_ff;
reg ack_bit_ff;
reg ack_rx_ff;
reg rx_mode_ff;
reg tx_mode_ff;
reg flag_set_p_ff;
reg arb_p_ff;
reg stop_p_ff;
reg cap_p_ff;
// bus monitor
reg scl_prev_ff;
reg sda_prev_ff;
reg busy_ff;

wire scl_s;
wire sda_s;
wire tick;
wire wr_ctrl;
wire wr_data;
wire go;
wire tx_bit;
wire own_bit;

// ------------------------------------------------------------------
// decode helpers
// ------------------------------------------------------------------
// register hit, used for every register write
function hit;
    input [2:0] addr;
    input [2:0] idx;
    begin
        hit = (addr == idx);
    end
endfunction

// status after the ninth clock of an address or data byte
function [7:0] byte_code;
    input addr_phase;
    input rd_dir;
    input nack;
    begin
        if (!addr_phase) begin
            byte_code = nack ? `ST_D_NACK : `ST_D_ACK;
        end else if (rd_dir) begin
            byte_code = nack ? `ST_R_NACK : `ST_R_ACK;
        end else begin
            byte_code = nack ? `ST_W_NACK : `ST_W_ACK;
        end
    end
endfunction

// ------------------------------------------------------------------
// pin synchronisers
// ------------------------------------------------------------------
pin_sync u_scl_sync (
    .clk(clk),
    .rst_n(rst_n),
    .pin(scl_i),
    .level(scl_s)
);

pin_sync u_sda_sync (
    .clk(clk),
    .rst_n(rst_n),
    .pin(sda_i),
    .level(sda_s)
);

// ------------------------------------------------------------------
// strobes
// ------------------------------------------------------------------
assign wr_ctrl = reg_wr && hit(reg_addr, `REG_CTRL);
assign wr_data = reg_wr && hit(reg_addr, `REG_DATA);
// writing one into the flag with the enable bit set in the same write resumes the engine
assign go = wr_ctrl && reg_wdata[`CTL_FLAG] && reg_wdata[`CTL_EN];
assign tick = (cnt_ff == QTR_LAST);
// we drive address bits and our own ack; the slave answers the address
assign tx_bit = (bit_ff == 4'd8) ? (addr_phase_ff ? 1'b1 : ack_bit_ff) :
                (addr_phase_ff ? shift_ff[7] : 1'b1);
assign own_bit = addr_phase_ff ? (bit_ff != 4'd8) : (bit_ff == 4'd8);

// ------------------------------------------------------------------
// quarter-bit divider and bus busy monitor
// ------------------------------------------------------------------
// busy follows START/STOP seen on the wire, including our own
always @(posedge clk) begin
    if (!rst_n) begin
        cnt_ff <= {CW{1'b0}};
        scl_prev_ff <= 1'b1;
        sda_prev_ff <= 1'b1;
        busy_ff <= 1'b0;
    end else begin
        cnt_ff <= tick ? {CW{1'b0}} : cnt_ff + 1'b1;
        scl_prev_ff <= scl_s;
        sda_prev_ff <= sda_s;
        if (scl_s && scl_prev_ff && sda_prev_ff && !sda_s) begin
            busy_ff <= 1'b1;
        end else if (scl_s && scl_prev_ff && !sda_prev_ff && sda_s) begin
            busy_ff <= 1'b0;
        end
    end
end

// ------------------------------------------------------------------
// bus engine
// ------------------------------------------------------------------
always @(posedge clk) begin
    if (!rst_n) begin
        state_ff <= S_IDLE;
        phase_ff <= 2'd0;
        bit_ff <= 4'd0;
        shift_ff <= 8'h00;
        scl_drv_ff <= 1'b0;
        sda_drv_ff <= 1'b0;
        hold_scl_ff <= 1'b0;
        rep_ff <= 1'b0;
        pend_ff <= 1'b0;
        addr_phase_ff <= 1'b0;
        rd_dir_ff <= 1'b0;
        ack_bit_ff <= 1'b1;
        ack_rx_ff <= 1'b1;
        rx_mode_ff <= 1'b0;
        tx_mode_ff <= 1'b0;
        status_ff <= `ST_IDLE;
        flag_set_p_ff <= 1'b0;
        arb_p_ff <= 1'b0;
        stop_p_ff <= 1'b0;
        cap_p_ff <= 1'b0;
    end else begin
        flag_set_p_ff <= 1'b0;
        arb_p_ff <= 1'b0;
        stop_p_ff <= 1'b0;
        cap_p_ff <= 1'b0;
        if (!iface_enable_ff && !go) begin
            // disabled: let go of both lines at once
            state_ff <= S_IDLE;
            scl_drv_ff <= 1'b0;
            sda_drv_ff <= 1'b0;
            pend_ff <= 1'b0;
            rx_mode_ff <= 1'b0;
            tx_mode_ff <= 1'b0;
        end else begin
            case (state_ff)
            S_IDLE: begin
                scl_drv_ff <= 1'b0;
                sda_drv_ff <= 1'b0;
                phase_ff <= 2'd0;
                if (go && reg_wdata[`CTL_STA]) begin
                    pend_ff <= 1'b1;
                end
                // start only once the wire is seen free
                if (pend_ff && !busy_ff && tick) begin
                    pend_ff <= 1'b0;
                    rep_ff <= 1'b0;
                    state_ff <= S_START;
                end
            end
            S_START: begin
                if (tick) begin
                    case (phase_ff)
                    2'd0: begin
                        sda_drv_ff <= 1'b0;
                        phase_ff <= 2'd1;
                    end
                    2'd1: begin
                        scl_drv_ff <= 1'b0;
                        phase_ff <= 2'd2;
                    end
                    2'd2: begin
                        // wait for a stretched clock before the edge
                        if (scl_s) begin
                            sda_drv_ff <= 1'b1;
                            phase_ff <= 2'd3;
                        end
                    end
                    default: begin
                        scl_drv_ff <= 1'b1;
                        hold_scl_ff <= 1'b1;
                        phase_ff <= 2'd0;
                        status_ff <= rep_ff ? `ST_RSTART : `ST_START;
                        flag_set_p_ff <= 1'b1;
                        state_ff <= S_HOLD;
                    end
                    endcase
                end
            end
            S_HOLD: begin
                // clock is held low while software inspects the status, except after lost arbitration
                scl_drv_ff <= hold_scl_ff;
                if (go) begin
                    phase_ff <= 2'd0;
                    bit_ff <= 4'd0;
                    case (status_ff)
                    `ST_START, `ST_RSTART: begin
                        shift_ff <= data_ff;
                        addr_phase_ff <= 1'b1;
                        rd_dir_ff <= data_ff[0];
                        state_ff <= S_BITS;
                    end
                    `ST_R_ACK, `ST_D_ACK: begin
                        shift_ff <= 8'hff;
                        addr_phase_ff <= 1'b0;
                        ack_bit_ff <= ~reg_wdata[`CTL_ACK];
                        state_ff <= S_BITS;
                    end
                    `ST_ARB: begin
                        // released already; restart when free if asked
                        pend_ff <= reg_wdata[`CTL_STA];
                        state_ff <= S_IDLE;
                    end
                    default: begin
                        // 48, 58 and the transmitter ends 18/20
                        if (reg_wdata[`CTL_STO]) begin
                            pend_ff <= reg_wdata[`CTL_STA];
                            state_ff <= S_STOP;
                        end else if (reg_wdata[`CTL_STA]) begin
                            // no STOP between: we keep the bus
                            rep_ff <= 1'b1;
                            state_ff <= S_START;
                        end
                    end
                    endcase
                end
            end
            S_BITS: begin
                if (tick) begin
                    case (phase_ff)
                    2'd0: begin
                        sda_drv_ff <= ~tx_bit;
                        phase_ff <= 2'd1;
                    end
                    2'd1: begin
                        scl_drv_ff <= 1'b0;
                        phase_ff <= 2'd2;
                    end
                    2'd2: begin
                        if (scl_s) begin
                            if (own_bit && tx_bit && !sda_s) begin
                                // someone else pulled low: we lost
                                sda_drv_ff <= 1'b0;
                                scl_drv_ff <= 1'b0;
                                hold_scl_ff <= 1'b0;
                                rx_mode_ff <= 1'b0;
                                tx_mode_ff <= 1'b0;
                                status_ff <= `ST_ARB;
                                flag_set_p_ff <= 1'b1;
                                arb_p_ff <= 1'b1;
                                state_ff <= S_HOLD;
                            end else begin
                                if (bit_ff == 4'd8) begin
                                    ack_rx_ff <= sda_s;
                                end else begin
                                    shift_ff <= {shift_ff[6:0], sda_s};
                                end
                                phase_ff <= 2'd3;
                            end
                        end
                    end
                    default: begin
                        scl_drv_ff <= 1'b1;
                        phase_ff <= 2'd0;
                        if (bit_ff == 4'd8) begin
                            // our ack stays put while the clock falls
                            hold_scl_ff <= 1'b1;
                            flag_set_p_ff <= 1'b1;
                            state_ff <= S_HOLD;
                            status_ff <= byte_code(addr_phase_ff, rd_dir_ff,
                                addr_phase_ff ? ack_rx_ff : ack_bit_ff);
                            if (addr_phase_ff) begin
                                rx_mode_ff <= rd_dir_ff;
                                tx_mode_ff <= ~rd_dir_ff;
                            end else begin
                                cap_p_ff <= 1'b1;
                            end
                        end else begin
                            bit_ff <= bit_ff + 4'd1;
                        end
                    end
                    endcase
                end
            end
            S_STOP: begin
                if (tick) begin
                    case (phase_ff)
                    2'd0: begin
                        sda_drv_ff <= 1'b1;
                        phase_ff <= 2'd1;
                    end
                    2'd1: begin
                        scl_drv_ff <= 1'b0;
                        phase_ff <= 2'd2;
                    end
                    2'd2: begin
                        if (scl_s) begin
                            sda_drv_ff <= 1'b0;
                            phase_ff <= 2'd3;
                        end
                    end
                    default: begin
                        stop_p_ff <= 1'b1;
                        status_ff <= `ST_IDLE;
                        rx_mode_ff <= 1'b0;
                        tx_mode_ff <= 1'b0;
                        hold_scl_ff <= 1'b0;
                        phase_ff <= 2'd0;
                        state_ff <= S_IDLE;
                    end
                    endcase
                end
            end
            default: begin
                state_ff <= S_IDLE;
            end
            endcase
        end
    end
end

// ------------------------------------------------------------------
// register file writes
// ------------------------------------------------------------------
// hardware sets win over software clears on every sticky bit
always @(posedge clk) begin
    if (!rst_n) begin
        job_done_flag_ff <= CTRL_INIT[`CTL_FLAG];
        ack_enable_ff <= 1'b0;
        start_request_ff <= 1'b0;
        stop_request_ff <= 1'b0;
        write_collision_flag_ff <= 1'b0;
        iface_enable_ff <= 1'b0;
        irq_enable_ff <= 1'b0;
        data_ff <= `DATA_RST;
        evt_ff <= {`EVT_W{1'b0}};
        mask_ff <= `MASK_RST;
    end else begin
        if (wr_ctrl) begin
            ack_enable_ff <= reg_wdata[`CTL_ACK];
            start_request_ff <= reg_wdata[`CTL_STA];
            iface_enable_ff <= reg_wdata[`CTL_EN];
            irq_enable_ff <= reg_wdata[`CTL_IE];
        end
        if (wr_ctrl) begin
            stop_request_ff <= reg_wdata[`CTL_STO];
        end else if (stop_p_ff) begin
            stop_request_ff <= 1'b0;
        end
        if (flag_set_p_ff) begin
            job_done_flag_ff <= 1'b1;
        end else if (wr_ctrl && reg_wdata[`CTL_FLAG]) begin
            job_done_flag_ff <= 1'b0;
        end
        // data may only change while the engine is parked
        if (wr_data && !job_done_flag_ff) begin
            write_collision_flag_ff <= 1'b1;
        end else if (wr_data) begin
            write_collision_flag_ff <= 1'b0;
        end
        if (cap_p_ff) begin
            data_ff <= shift_ff;
        end else if (wr_data && job_done_flag_ff) begin
            data_ff <= reg_wdata;
        end
        evt_ff <= (evt_ff & ~((reg_wr && hit(reg_addr, `REG_EVT)) ?
                  reg_wdata[`EVT_W-1:0] : {`EVT_W{1'b0}})) |
                  {stop_p_ff, arb_p_ff, flag_set_p_ff};
        if (reg_wr && hit(reg_addr, `REG_MASK)) begin
            mask_ff <= reg_wdata[`EVT_W-1:0];
        end
    end
end

// ------------------------------------------------------------------
// read port
// ------------------------------------------------------------------
// data stands for exactly the cycle after the read strobe
always @(posedge clk) begin
    if (!rst_n) begin
        rdata_ff <= 8'h00;
    end else if (reg_rd) begin
        case (reg_addr)
        `REG_CTRL: rdata_ff <= {job_done_flag_ff, ack_enable_ff,
                                start_request_ff, stop_request_ff,
                                write_collision_flag_ff, iface_enable_ff,
                                1'b0, irq_enable_ff};
        `REG_STATUS: rdata_ff <= {status_ff[7:3], 3'b000};
        `REG_DATA: rdata_ff <= data_ff;
        `REG_EVT: rdata_ff <= {{(8-`EVT_W){1'b0}}, evt_ff};
        `REG_MASK: rdata_ff <= {{(8-`EVT_W){1'b0}}, mask_ff};
        default: rdata_ff <= 8'h00;
        endcase
    end else begin
        rdata_ff <= 8'h00;
    end
end

// ------------------------------------------------------------------
// outputs
// ------------------------------------------------------------------
// open drain: only ever pull low, the enable says when
assign scl_o = 1'b0;
assign sda_o = 1'b0;
assign scl_oe = scl_drv_ff;
assign sda_oe = sda_drv_ff;
assign irq = |(evt_ff & mask_ff);
assign reg_rdata = rdata_ff;
assign master_rx_mode = rx_mode_ff;
assign master_tx_mode = tx_mode_ff;

endmodule // two_wire_master_receiver

// ==== test/slave_tx_model.sv ====
// behavioural slave transmitter on the two-wire bus
`timescale 1ns/1ps
module slave_tx_model #(
    parameter ADDR = 7'h2a
) (
    input wire scl,
    input wire sda,
    output reg sda_oe
);
    reg [3:0] cnt;
    reg [7:0] sh;
    reg [7:0] tx;
    reg act, addr_ph, rd;
    initial begin
        sda_oe = 1'b0;
        act = 1'b0;
        tx = 8'ha5;
    end
    // start opens a frame, stop closes it
    always @(negedge sda) begin
        if (scl) begin
            act = 1'b1;
            addr_ph = 1'b1;
            cnt = 4'd0;
        end
    end
    always @(posedge sda) begin
        if (scl)
            act = 1'b0;
    end
    // shift on rising clock; a nack from the master ends our turn
    always @(posedge scl) begin
        if (act) begin
            if (cnt < 4'd8)
                sh = {sh[6:0], sda};
            else if (!addr_ph && sda)
                act = 1'b0;
            cnt = cnt + 4'd1;
        end
    end
    // change only while clock is low so no false start or stop appears
    always @(negedge scl) begin
        if (act && cnt == 4'd9) begin
            cnt = 4'd0;
            tx = addr_ph ? tx : tx + 8'h11;
            act = !addr_ph || sh[7:1] == ADDR;
            rd = addr_ph ? sh[0] : rd;
            addr_ph = 1'b0;
        end
        sda_oe = act && (addr_ph ? cnt == 4'd8 && sh[7:1] == ADDR
            : rd && cnt < 4'd8 && !tx[7 - cnt]);
    end
endmodule // slave_tx_model

// ==== test/two_wire_master_receiver_props.sv ====
// assertions on the ports of the two-wire master receiver
`timescale 1ns/1ps
module two_wire_master_receiver_props (
    input wire clk,
    input wire rst_n,
    input wire [2:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_rdata,
    input wire scl_i,
    input wire scl_o,
    input wire scl_oe,
    input wire sda_i,
    input wire sda_o,
    input wire sda_oe,
    input wire irq,
    input wire master_rx_mode,
    input wire master_tx_mode
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    // register side: read answers and flag handling
    property p_pre;
        reg_rd && reg_addr == 3'h1 |=> reg_rdata[2:0] == 3'h0;
    endproperty
    a_pre: assert property (p_pre) else $error("prescaler bits set");
    property p_rsv;
        reg_rd && reg_addr == 3'h0 |=> reg_rdata[1] == 1'b0;
    endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bit set");
    property p_once;
        reg_rd ##1 !reg_rd |=> reg_rdata == 8'h00;
    endproperty
    a_once: assert property (p_once) else $error("read data lingers");
    property p_mode;
        !(master_rx_mode && master_tx_mode);
    endproperty
    a_mode: assert property (p_mode) else $error("both modes");
    property p_sticky;
        irq && !reg_wr |=> irq;
    endproperty
    a_sticky: assert property (p_sticky) else $error("irq dropped");
    property p_mask;
        reg_wr && reg_addr == 3'h4 && reg_wdata == 8'h00 |=> !irq;
    endproperty
    a_mask: assert property (p_mask) else $error("masked irq");
    // bus side: stop releases both lines, start pulls data low
    property p_stop;
        reg_wr && reg_addr == 3'h0 && reg_wdata[7:4] == 4'h9 && reg_wdata[2]
            |=> ##[0:999] !scl_oe && !sda_oe;
    endproperty
    a_stop: assert property (p_stop) else $error("no release");
    property p_start;
        reg_wr && reg_addr == 3'h0 && reg_wdata[7:4] == 4'ha && reg_wdata[2]
            && !scl_oe |=> ##[1:999] sda_oe;
    endproperty
    a_start: assert property (p_start) else $error("no start");
    c_rx: cover property ($rose(master_rx_mode));
    c_tx: cover property ($rose(master_tx_mode));
    c_irq: cover property ($rose(irq));
endmodule // two_wire_master_receiver_props

bind two_wire_master_receiver two_wire_master_receiver_props props_i (
    .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .scl_i(scl_i),
    .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_i), .sda_o(sda_o),
    .sda_oe(sda_oe), .irq(irq), .master_rx_mode(master_rx_mode),
    .master_tx_mode(master_tx_mode));

// ==== test/two_wire_master_receiver_tb.sv ====
// self-checking bench for the two-wire master receiver
`timescale 1ns/1ps
module two_wire_master_receiver_tb;
    reg clk, rst_n, reg_wr, reg_rd;
    reg [2:0] reg_addr;
    reg [7:0] reg_wdata, v;
    wire [7:0] reg_rdata;
    wire scl_oe, sda_oe, slv_oe, irq, rx_mode, tx_mode;
    integer fails, check_count, n;
    // open-drain wires with pull-ups
    wire scl = ~scl_oe;
    wire sda = ~(sda_oe | slv_oe);
    two_wire_master_receiver #(.QTR(4)) dut (
        .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .scl_i(scl), .scl_o(), .scl_oe(scl_oe),
        .sda_i(sda), .sda_o(), .sda_oe(sda_oe), .irq(irq),
        .master_rx_mode(rx_mode), .master_tx_mode(tx_mode));
    slave_tx_model #(.ADDR(7'h2a)) peer (.scl(scl), .sda(sda), .sda_oe(slv_oe));
    // system clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task chk(input [7:0] got, input [7:0] exp);
        begin
            check_count = check_count + 1;
            if (got !== exp) begin
                fails = fails + 1;
                $display("MISMATCH %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    task close_out;
        begin
            $display("checks %0d mismatches %0d", check_count, fails);
            if (fails == 0 && check_count > 0)
                $display("bench passed");
            else
                $display("bench failed");
            $finish;
        end
    endtask
    task wr(input [2:0] a, input [7:0] d);
        begin
            @(posedge clk);
            reg_wr <= 1'b1;
            reg_addr <= a;
            reg_wdata <= d;
            @(posedge clk);
            reg_wr <= 1'b0;
        end
    endtask
    // read data stand only in the cycle after the strobe
    task rd(input [2:0] a);
        begin
            @(posedge clk);
            reg_rd <= 1'b1;
            reg_addr <= a;
            @(posedge clk);
            reg_rd <= 1'b0;
            #1 v = reg_rdata;
        end
    endtask
    // clear events, write control, wait for the unmasked event
    task go(input [7:0] m, input [7:0] c, input [7:0] code);
        begin
            wr(3'h4, m);
            wr(3'h3, 8'h07);
            wr(3'h0, c);
            n = 0;
            while (irq !== 1'b1 && n < 3000) begin
                @(posedge clk);
                n = n + 1;
            end
            if (n == 3000) begin
                fails = fails + 1;
                close_out;
            end
            rd(3'h1);
            chk(v, code);
        end
    endtask
    task t_reset;
        begin
            rd(3'h0);
            chk(v, 8'h00);
            rd(3'h1);
            chk(v, 8'hf8);
            rd(3'h2);
            chk(v, 8'hff);
            rd(3'h5);
            chk(v, 8'h00);
            wr(3'h2, 8'h55);
            rd(3'h0);
            chk(v & 8'h08, 8'h08);
            $display("test reset done");
        end
    endtask
    task t_read;
        begin
            go(8'h01, 8'ha4, 8'h08);
            wr(3'h4, 8'h00);
            #1 chk(irq, 8'h00);
            wr(3'h2, 8'h55);
            go(8'h01, 8'hc4, 8'h40);
            chk(rx_mode, 8'h01);
            go(8'h01, 8'hc4, 8'h50);
            rd(3'h2);
            chk(v, 8'ha5);
            go(8'h01, 8'h84, 8'h58);
            rd(3'h2);
            chk(v, 8'hb6);
            go(8'h04, 8'h94, 8'hf8);
            rd(3'h0);
            chk(v & 8'h10, 8'h00);
            $display("test read done");
        end
    endtask
    task t_restart;
        begin
            go(8'h01, 8'ha4, 8'h08);
            wr(3'h2, 8'h23);
            go(8'h01, 8'h84, 8'h48);
            go(8'h01, 8'ha4, 8'h10);
            wr(3'h2, 8'h55);
            go(8'h01, 8'h84, 8'h40);
            go(8'h01, 8'h84, 8'h58);
            go(8'h01, 8'hb4, 8'h08);
            wr(3'h2, 8'h54);
            go(8'h01, 8'h84, 8'h18);
            chk(tx_mode, 8'h01);
            go(8'h04, 8'h94, 8'hf8);
            $display("test restart done");
        end
    endtask
    initial begin
        fails = 0;
        check_count = 0;
        rst_n = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 3'h0;
        reg_wdata = 8'h00;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        t_reset;
        t_read;
        t_restart;
        close_out;
    end
endmodule // two_wire_master_receiver_tb
